// ==== rwc_pkg.sv ====
package rwc_pkg;
    // apb byte offsets, one aligned word each
    localparam logic [7:0]  OFF_RESET_STATUS = 8'h00;
    localparam logic [7:0]  OFF_OPTION_A     = 8'h04;
    localparam logic [7:0]  OFF_OPTION_B     = 8'h08;
    localparam logic [7:0]  OFF_WDOG_COUNT   = 8'h0C;
    // reset_source_status bit positions
    localparam int          ST_POR           = 7;
    localparam int          ST_PIN           = 6;
    localparam int          ST_WDOG          = 5;
    localparam int          ST_ILLEGAL_OPCODE_RESET          = 4;
    localparam int          ST_ILLEGAL_ADDRESS_RESET          = 3;
    localparam int          ST_LVD           = 1;
    localparam logic [7:0]  STATUS_POR_VALUE = 8'h80;
    // option register fields and reset values
    localparam int          OPTA_WD_EN       = 7;
    localparam int          OPTA_WD_TMO      = 6;
    localparam int          OPTA_PIN_EN      = 0;
    localparam int          OPTB_WD_CLK      = 7;
    localparam logic [7:0]  OPTA_RESET       = 8'hC0;
    localparam logic [7:0]  OPTB_RESET       = 8'h00;
    // processor reset state and vector map
    localparam logic [15:0] RESET_VEC_HI     = 16'hFFFE;
    localparam logic [15:0] RESET_VEC_LO     = 16'hFFFF;
    localparam logic [15:0] IRQ_VEC_TOP      = 16'hFFFC;
    localparam logic [15:0] SP_RESET         = 16'h00FF;
    localparam int          CCR_I_BIT        = 3;
    localparam logic [7:0]  CCR_RESET        = 8'h08;
    localparam int          NUM_IRQ          = 8;
    localparam logic [2:0]  PUSH_LAST        = 3'h4;
    localparam logic [2:0]  FILL_LAST        = 3'h2;
    // watchdog overflow counts
    localparam int          WD_W             = 19;
    localparam logic [18:0] WD_32K_SHORT     = 19'h0_0400;
    localparam logic [18:0] WD_32K_LONG      = 19'h0_2000;
    localparam logic [18:0] WD_BUS_SHORT     = 19'h0_2000;
    localparam logic [18:0] WD_BUS_LONG      = 19'h4_0000;
    // cycles the internal reset is held after any source
    localparam logic [2:0]  RST_HOLD_CYC     = 3'h4;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0]  acc;
        logic [7:0]  idx;
        logic [7:0]  condition_code_reg;
    } rwc_cpu_regs_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } rwc_mem_bus_t;

    // overflow count for the selected clock and time-out
    function automatic logic [18:0] wd_limit(input logic clk_sel, input logic tmo);
        if (clk_sel) begin
            wd_limit = tmo ? WD_BUS_LONG : WD_BUS_SHORT;
        end else begin
            wd_limit = tmo ? WD_32K_LONG : WD_32K_SHORT;
        end
    endfunction : wd_limit

    // lowest index wins: index 0 has the highest priority
    function automatic logic [2:0] prio_pick(input logic [7:0] req);
        prio_pick = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                prio_pick = 3'(i);
            end
        end
    endfunction : prio_pick
endpackage : rwc_pkg

// ==== rwc_top.sv ====
`timescale 1ns/1ps
module rwc_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  reset_pin_n,
    input  wire logic                  low_voltage_detect,
    input  wire logic                  illegal_opcode_reset,
    input  wire logic                  illegal_address_reset,
    input  wire logic                  debug_force_reset,
    input  wire logic                  clk32k_tick,
    input  wire logic                  stop_mode,
    input  wire logic                  debug_mode,
    output logic                       system_reset,
    output logic                       peripherals_disabled,
    output logic                       gpio_force_input,
    output logic                       gpio_pullup_off,
    input  wire logic [7:0]            irq_flags,
    input  wire logic [7:0]            irq_enables,
    input  wire logic                  instr_boundary,
    input  wire logic                  rti_start,
    input  wire rwc_pkg::rwc_cpu_regs_t core_regs,
    output rwc_pkg::rwc_mem_bus_t      mem,
    input  wire logic [7:0]            mem_rdata,
    output rwc_pkg::rwc_cpu_regs_t     seq_regs,
    output logic [23:0]                prefetch_q,
    output logic                       seq_busy,
    output logic                       seq_done
);
    import rwc_pkg::*;

    typedef enum {
        S_HOLD, S_RVEC_HI, S_RVEC_LO, S_RUN, S_PUSH, S_IVEC_HI, S_IVEC_LO, S_POP, S_FILL
    } rwc_state_t;

    rwc_state_t        state;
    rwc_state_t        next_state;
    logic [2:0]        step;
    logic [2:0]        rst_cnt;
    logic [7:0]        status;
    logic [7:0]        opt_a;
    logic [7:0]        opt_b;
    logic              a_locked;
    logic              b_locked;
    logic [WD_W-1:0]   wd_cnt;
    logic [WD_W-1:0]   next_wd_cnt;
    logic              stop_q;
    logic [15:0]       vec_addr;
    logic              done_q;

    // apb decode
    wire apb_wr     = psel & penable & pwrite;
    wire hit_status = (paddr == OFF_RESET_STATUS);
    wire hit_opt_a  = (paddr == OFF_OPTION_A);
    wire hit_opt_b  = (paddr == OFF_OPTION_B);
    wire hit_wdog   = (paddr == OFF_WDOG_COUNT);
    wire mapped     = hit_status | hit_opt_a | hit_opt_b | hit_wdog;
    wire wr_status  = apb_wr & hit_status;
    wire wr_opt_a   = apb_wr & hit_opt_a & ~a_locked;
    wire wr_opt_b   = apb_wr & hit_opt_b & ~b_locked;

    // zero wait states; an unmapped address errors and reads zero
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = hit_status ? {24'h00_0000, status} :
                     hit_opt_a  ? {24'h00_0000, opt_a} :
                     hit_opt_b  ? {24'h00_0000, opt_b} :
                     hit_wdog   ? {13'h0000, wd_cnt} : 32'h0000_0000;

    // option fields steering the watchdog and the pin reset
    wire wd_en   = opt_a[OPTA_WD_EN];
    wire wd_tmo  = opt_a[OPTA_WD_TMO];
    wire pin_en  = opt_a[OPTA_PIN_EN];
    wire wd_clk  = opt_b[OPTB_WD_CLK];

    // reset sources; the pin only counts when enabled
    wire in_reset   = (rst_cnt != 3'h0);
    wire pin_rst    = pin_en & ~reset_pin_n;
    wire wd_tick    = wd_clk ? 1'b1 : clk32k_tick;
    wire wd_service = wr_status | wr_opt_a | wr_opt_b;
    wire wd_ovf     = wd_en & wd_tick & ~debug_mode & ~stop_mode & ~wd_service & ~in_reset
                      & (wd_cnt == (wd_limit(wd_clk, wd_tmo) - 19'h0_0001));
    wire any_src    = pin_rst | low_voltage_detect | illegal_opcode_reset
                      | illegal_address_reset | debug_force_reset | wd_ovf;
    wire rst_start  = any_src & ~in_reset;

    // reset held for a few cycles; a new source is ignored while held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= RST_HOLD_CYC;
        end else if (rst_start) begin
            rst_cnt <= RST_HOLD_CYC;
        end else if (in_reset) begin
            rst_cnt <= rst_cnt - 3'h1;
        end
    end

    // pins and peripherals stay quiet while reset is held
    assign system_reset         = in_reset;
    assign peripherals_disabled = in_reset;
    assign gpio_force_input     = in_reset;
    assign gpio_pullup_off      = in_reset;

    // latest source is recorded; a debug-forced reset leaves it as it was
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= STATUS_POR_VALUE;
        end else if (rst_start && !(debug_force_reset && !(any_src & ~debug_force_reset))) begin
            status <= '0;
            status[ST_PIN]  <= pin_rst;
            status[ST_LVD]  <= low_voltage_detect;
            status[ST_WDOG] <= wd_ovf;
            status[ST_ILLEGAL_OPCODE_RESET] <= illegal_opcode_reset;
            status[ST_ILLEGAL_ADDRESS_RESET] <= illegal_address_reset;
        end
    end

    // write-once options: defaults restored and unlocked by every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_a    <= OPTA_RESET;
            opt_b    <= OPTB_RESET;
            a_locked <= 1'b0;
            b_locked <= 1'b0;
        end else if (in_reset) begin
            opt_a    <= OPTA_RESET;
            opt_b    <= OPTB_RESET;
            a_locked <= 1'b0;
            b_locked <= 1'b0;
        end else begin
            if (wr_opt_a) begin
                opt_a    <= pwdata[7:0];
                a_locked <= 1'b1;
            end
            if (wr_opt_b) begin
                opt_b    <= pwdata[7:0];
                b_locked <= 1'b1;
            end
        end
    end

    // watchdog next value; 19 bits cover the longest count
    wire stop_rise = stop_mode & ~stop_q;
    always_comb begin
        next_wd_cnt = wd_cnt;
        if (in_reset || wd_ovf || wd_service || !wd_en) begin
            next_wd_cnt = '0;
        end else if (debug_mode) begin
            next_wd_cnt = wd_cnt;
        end else if (stop_mode) begin
            // 32 kHz: zero on entry and held there; bus: frozen
            if (!wd_clk && stop_rise) begin
                next_wd_cnt = '0;
            end else begin
                next_wd_cnt = wd_cnt;
            end
        end else if (wd_tick) begin
            next_wd_cnt = wd_cnt + 19'h0_0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt <= '0;
            stop_q <= 1'b0;
        end else begin
            wd_cnt <= next_wd_cnt;
            stop_q <= stop_mode;
        end
    end

    // interrupt qualification and priority
    wire [7:0] irq_live  = irq_flags & irq_enables;
    wire       irq_qual  = (|irq_live) & ~core_regs.condition_code_reg[CCR_I_BIT];
    wire [2:0] irq_win   = prio_pick(irq_live);
    wire [15:0] irq_vec  = IRQ_VEC_TOP - {12'h000, irq_win, 1'b0};
    wire       take_irq  = (state == S_RUN) & instr_boundary & irq_qual & ~rti_start;
    wire       take_rti  = (state == S_RUN) & rti_start;

    // byte pushed at each stacking step; no index high byte exists here
    wire [7:0] push_byte = (step == 3'h0) ? seq_regs.pc[7:0] :
                           (step == 3'h1) ? seq_regs.pc[15:8] :
                           (step == 3'h2) ? seq_regs.idx :
                           (step == 3'h3) ? seq_regs.acc : seq_regs.condition_code_reg;

    // memory requests follow the sequencer state
    always_comb begin
        mem = '0;
        case (state)
            S_RVEC_HI: begin
                mem.req  = 1'b1;
                mem.addr = RESET_VEC_HI;
            end
            S_RVEC_LO: begin
                mem.req  = 1'b1;
                mem.addr = RESET_VEC_LO;
            end
            S_PUSH: begin
                mem.req   = 1'b1;
                mem.we    = 1'b1;
                mem.addr  = seq_regs.sp;
                mem.wdata = push_byte;
            end
            S_IVEC_HI: begin
                mem.req  = 1'b1;
                mem.addr = vec_addr;
            end
            S_IVEC_LO: begin
                mem.req  = 1'b1;
                mem.addr = vec_addr + 16'h0001;
            end
            S_POP: begin
                mem.req  = 1'b1;
                mem.addr = seq_regs.sp + 16'h0001;
            end
            S_FILL: begin
                mem.req  = 1'b1;
                mem.addr = seq_regs.pc + {13'h0000, step};
            end
            default: begin
                mem = '0;
            end
        endcase
    end

    // state transitions; any reset source restarts from hold
    always_comb begin
        next_state = state;
        case (state)
            S_HOLD:    next_state = in_reset ? S_HOLD : S_RVEC_HI;
            S_RVEC_HI: next_state = S_RVEC_LO;
            S_RVEC_LO: next_state = S_FILL;
            S_RUN:     next_state = take_rti ? S_POP : (take_irq ? S_PUSH : S_RUN);
            S_PUSH:    next_state = (step == PUSH_LAST) ? S_IVEC_HI : S_PUSH;
            S_IVEC_HI: next_state = S_IVEC_LO;
            S_IVEC_LO: next_state = S_FILL;
            S_POP:     next_state = (step == PUSH_LAST) ? S_FILL : S_POP;
            S_FILL:    next_state = (step == FILL_LAST) ? S_RUN : S_FILL;
            default:   next_state = S_HOLD;
        endcase
        if (rst_start || in_reset) begin
            next_state = S_HOLD;
        end
    end

    assign seq_busy = (state != S_RUN);
    assign seq_done = done_q;

    // sequencer datapath: register copy, step count, prefetch queue
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= S_HOLD;
            step       <= 3'h0;
            vec_addr   <= '0;
            prefetch_q <= '0;
            done_q     <= 1'b0;
            seq_regs   <= '0;
        end else begin
            state  <= next_state;
            done_q <= (state == S_FILL) && (step == FILL_LAST) && !in_reset && !rst_start;
            step   <= (next_state != state) ? 3'h0 : step + 3'h1;
            case (state)
                S_HOLD: begin
                    seq_regs.sp  <= SP_RESET;
                    seq_regs.condition_code_reg <= CCR_RESET;
                    seq_regs.acc <= '0;
                    seq_regs.idx <= '0;
                end
                S_RVEC_HI: seq_regs.pc[15:8] <= mem_rdata;
                S_RVEC_LO: seq_regs.pc[7:0]  <= mem_rdata;
                S_RUN: begin
                    // core's pc is already the next instruction's address
                    if (take_irq || take_rti) begin
                        seq_regs <= core_regs;
                    end
                    vec_addr <= irq_vec;
                end
                S_PUSH: begin
                    seq_regs.sp <= seq_regs.sp - 16'h0001;
                    if (step == PUSH_LAST) begin
                        seq_regs.condition_code_reg[CCR_I_BIT] <= 1'b1;
                    end
                end
                S_IVEC_HI: seq_regs.pc[15:8] <= mem_rdata;
                S_IVEC_LO: seq_regs.pc[7:0]  <= mem_rdata;
                S_POP: begin
                    seq_regs.sp <= seq_regs.sp + 16'h0001;
                    case (step)
                        3'h0:    seq_regs.condition_code_reg       <= mem_rdata;
                        3'h1:    seq_regs.acc       <= mem_rdata;
                        3'h2:    seq_regs.idx       <= mem_rdata;
                        3'h3:    seq_regs.pc[15:8]  <= mem_rdata;
                        default: seq_regs.pc[7:0]   <= mem_rdata;
                    endcase
                end
                S_FILL: begin
                    // three bytes queued, oldest in the low byte
                    prefetch_q <= {mem_rdata, prefetch_q[23:8]};
                end
                default: begin
                    seq_regs <= seq_regs;
                end
            endcase
        end
    end

    // checks
    sequence s_entry;
        (state == S_RUN) && take_irq;
    endsequence

    sequence s_first_push;
        (state == S_PUSH) && mem.we && (mem.wdata == seq_regs.pc[7:0]);
    endsequence

    AST_RVEC_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        (state == S_RVEC_HI) |-> (mem.addr == RESET_VEC_HI) ##1 (mem.addr == RESET_VEC_LO))
        else $error("reset vector not fetched high then low");

    AST_SP_MASK_INIT: assert property (@(posedge pclk) disable iff (!presetn)
        (state == S_RVEC_HI) |-> (seq_regs.sp == SP_RESET) && seq_regs.condition_code_reg[CCR_I_BIT])
        else $error("stack pointer or mask not initialised by reset");

    AST_PINS_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(system_reset) |-> (peripherals_disabled && gpio_force_input)[*4])
        else $error("peripherals or pins active during reset");

    AST_WD_OVERFLOW: assert property (@(posedge pclk) disable iff (!presetn)
        wd_ovf |=> system_reset && status[ST_WDOG] && (wd_cnt == '0))
        else $error("watchdog overflow did not reset the system");

    AST_SERVICE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_status && !rst_start) |=> (wd_cnt == '0) && $stable(status))
        else $error("status write did not clear watchdog or changed status");

    AST_WRITE_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_wr && hit_opt_a && a_locked && !in_reset) |=> $stable(opt_a))
        else $error("locked option register changed");

    AST_BDM_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (debug_mode && wd_en && !in_reset && !wd_service) |=> $stable(wd_cnt))
        else $error("watchdog counted in debug mode");

    AST_STOP_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_mode && !stop_q && !wd_clk && !debug_mode) |=> (wd_cnt == '0))
        else $error("watchdog not cleared on stop entry with slow clock");

    AST_STACK_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
        s_entry ##1 s_first_push |-> ##4 (mem.wdata == seq_regs.condition_code_reg)
        ##1 (seq_regs.sp == $past(seq_regs.sp, 1) - 16'h0001) && !mem.we)
        else $error("stack frame order or final pointer wrong");

    AST_RTI_FILL: assert property (@(posedge pclk) disable iff (!presetn)
        (take_rti && !rst_start) |=> (state == S_POP)[*5] ##1 (state == S_FILL)[*3]
        ##1 (state == S_RUN))
        else $error("return did not unstack five then prefetch three");
endmodule : rwc_top

// ==== rwc_mem_model.sv ====
`timescale 1ns/1ps
module rwc_mem_model
    import rwc_pkg::*;
(
    input  wire logic           pclk,
    input  wire rwc_pkg::rwc_mem_bus_t mem,
    output logic [7:0]          mem_rdata
);
    logic [7:0] junk = 8'h00;
    // idle bus shows a changing pattern, never a stale byte
    always @(posedge pclk) junk <= junk + 8'h01;
    // same-cycle answer, a fixed scramble of the address
    assign mem_rdata = (mem.req && !mem.we) ? (mem.addr[7:0] ^ 8'h3C) : ~junk;
endmodule : rwc_mem_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import rwc_pkg::*;
    logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tick = 0;
    logic [7:0]    paddr = 8'h00, irq_flags = 8'h00, irq_en = 8'h00, mem_rdata;
    logic [31:0]   pwdata = 32'h0000_0000, prdata, rd;
    logic          pready, pslverr, err, ib = 0, return_from_interrupt_instr = 0, sys_rst, pd, gi, gp, busy, done;
    logic [2:0]    src = 3'h0;
    logic          pin_n = 1, dbg_rst = 0, stop = 0, dbg = 0;
    logic [23:0]   pq;
    rwc_cpu_regs_t core = '0, sq;
    rwc_mem_bus_t  mem;
    logic [23:0]   wlog [$];
    int            fail_count = 0, samples_checked = 0, cyc = 0;
    rwc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin_n(pin_n), .low_voltage_detect(src[0]),
        .illegal_opcode_reset(src[1]), .illegal_address_reset(src[2]),
        .debug_force_reset(dbg_rst), .clk32k_tick(tick), .stop_mode(stop), .debug_mode(dbg),
        .system_reset(sys_rst), .peripherals_disabled(pd), .gpio_force_input(gi),
        .gpio_pullup_off(gp), .irq_flags(irq_flags), .irq_enables(irq_en),
        .instr_boundary(ib), .rti_start(return_from_interrupt_instr), .core_regs(core), .mem(mem),
        .mem_rdata(mem_rdata), .seq_regs(sq), .prefetch_q(pq), .seq_busy(busy),
        .seq_done(done));
    rwc_mem_model i_mem (.pclk(pclk), .mem(mem), .mem_rdata(mem_rdata));
    initial forever #2 pclk = ~pclk;
    // slow tick every 8 cycles; log every stacking write
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        tick <= (cyc % 8 == 0);
        if (mem.req && mem.we) wlog.push_back({mem.addr, mem.wdata});
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // setup, then access until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wait_done;
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge pclk);
        chk(done, 1'b1);
    endtask : wait_done
    task automatic t_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({sys_rst, pd, gi, gp}, 4'hF);
        wait_done();
        chk(sq.pc, 16'hC2C3);
        chk(sq.sp, SP_RESET);
        chk(sq.condition_code_reg[CCR_I_BIT], 1'b1);
        chk(pq, 24'hF9_F8FF);
        apb(0, OFF_OPTION_A, 0);
        chk(rd, OPTA_RESET);
        apb(0, OFF_OPTION_B, 0);
        chk(rd, OPTB_RESET);
        apb(1, OFF_RESET_STATUS, 32'hFFFF_FFFF);
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd < 32'h0000_0004, 1'b1);
        apb(0, OFF_RESET_STATUS, 0);
        chk(rd, STATUS_POR_VALUE);
        apb(0, 8'h40, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
    endtask : t_reset
    task automatic t_lock;
        apb(1, OFF_OPTION_A, 32'h0000_0040);
        apb(1, OFF_OPTION_A, 32'h0000_00C1);
        apb(0, OFF_OPTION_A, 0);
        chk(rd, 32'h0000_0040);
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd, 32'h0000_0000);
    endtask : t_lock
    // bus clock, short count: overflow after 2^13 cycles
    task automatic t_wdog;
        int n;
        t_reset();
        apb(1, OFF_OPTION_B, 32'h0000_0080);
        apb(1, OFF_OPTION_A, 32'h0000_0080);
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd < 32'h0000_0004, 1'b1);
        for (n = 0; n < 9000 && sys_rst !== 1'b1; n++) @(negedge pclk);
        chk(n > 8100 && sys_rst === 1'b1, 1'b1);
        wait_done();
        apb(0, OFF_RESET_STATUS, 0);
        chk(rd, 32'h0000_0020);
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd < 32'h0000_0004, 1'b1);
    endtask : t_wdog
    task automatic t_src;
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            src <= 3'(1 << i);
            @(posedge pclk);
            src <= 3'h0;
            wait_done();
            apb(0, OFF_RESET_STATUS, 0);
            chk(rd, 32'(1) << (i == 0 ? ST_LVD : i == 1 ? ST_ILLEGAL_OPCODE_RESET : ST_ILLEGAL_ADDRESS_RESET));
        end
    endtask : t_src
    task automatic t_irq;
        @(posedge pclk);
        core <= '{pc: 16'h1234, sp: 16'h00F0, acc: 8'hA5, idx: 8'h5A, condition_code_reg: 8'h08};
        {irq_flags, irq_en, ib} <= {8'h06, 8'h06, 1'b1};
        repeat (4) @(negedge pclk);
        chk(busy, 1'b0);
        wlog.delete();
        @(posedge pclk);
        core.condition_code_reg <= 8'h00;
        @(posedge pclk);
        {ib, irq_flags} <= 9'h000;
        wait_done();
        chk(wlog.size(), 5);
        chk(wlog[0], 24'h00_F034);
        chk(wlog[2], 24'h00_EE5A);
        chk(wlog[4], 24'h00_EC00);
        chk({sq.pc, sq.sp}, 32'hC6C7_00EB);
        chk(sq.condition_code_reg[CCR_I_BIT], 1'b1);
        @(posedge pclk);
        core.sp <= 16'h00EB;
        return_from_interrupt_instr <= 1'b1;
        @(posedge pclk);
        return_from_interrupt_instr <= 1'b0;
        wait_done();
        chk({sq.pc, sq.sp}, 32'hD3CC_00F0);
        chk(pq, 24'hF2_F1F0);
    endtask : t_irq
    // debug-forced and pin resets, then the counter in debug and in stop
    task automatic t_modes;
        logic [31:0] r1;
        @(posedge pclk);
        dbg_rst <= 1'b1;
        @(posedge pclk);
        dbg_rst <= 1'b0;
        wait_done();
        apb(0, OFF_RESET_STATUS, 0);
        chk(rd, 32'(1) << ST_ILLEGAL_ADDRESS_RESET);
        @(posedge pclk);
        pin_n <= 1'b0;
        repeat (4) @(negedge pclk);
        chk(sys_rst, 1'b0);
        apb(1, OFF_OPTION_A, 32'h0000_00C1);
        @(posedge pclk);
        pin_n <= 1'b1;
        wait_done();
        apb(0, OFF_RESET_STATUS, 0);
        chk(rd, 32'(1) << ST_PIN);
        repeat (40) @(posedge pclk);
        dbg <= 1'b1;
        apb(0, OFF_WDOG_COUNT, 0);
        r1 = rd;
        repeat (24) @(posedge pclk);
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd, r1);
        chk(r1 > 32'h0000_0002, 1'b1);
        dbg <= 1'b0;
        stop <= 1'b1;
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd, 32'h0000_0000);
        stop <= 1'b0;
        apb(1, OFF_OPTION_B, 32'h0000_0080);
        repeat (20) @(posedge pclk);
        stop <= 1'b1;
        apb(0, OFF_WDOG_COUNT, 0);
        r1 = rd;
        repeat (10) @(posedge pclk);
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd, r1);
        chk(r1 > 32'h0000_0010, 1'b1);
        stop <= 1'b0;
        apb(0, OFF_WDOG_COUNT, 0);
        chk(rd > r1, 1'b1);
    endtask : t_modes
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        #100us;
        fail_count++;
        test_done();
    end
    initial begin
        t_reset();
        t_lock();
        t_src();
        t_irq();
        t_modes();
        t_wdog();
        test_done();
    end
endmodule : tb_top
